// >>> dv/gpcp_assertions.sv
// Purpose: port-level timing and value checks of the pin config port
// Assumes: one clock domain, async active-high reset
// Notes: bound to the top module by the statement after the module
`timescale 1ns/1ps
module gpcp_assertions #(
    parameter logic [23:0] IMPL = 24'h1F_801F
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic cfg_rd,
    input wire logic [7:0] cfg_index,
    input wire logic [7:0] cfg_rdata_q,
    input wire logic port_active,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [3:0] io_addr,
    input wire logic [7:0] io_rdata_q,
    input wire logic [23:0] pin_in,
    input wire logic [23:0] pin_out_q,
    input wire logic [23:0] pin_pullup_q
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_dead_read;
        io_rd && !port_active;
    endsequence
    sequence s_in0_read;
        io_rd && port_active && io_addr == 4'h1;
    endsequence
    inactive_read_zero_a: assert property (s_dead_read |=> io_rdata_q == 0)
        else $error("runtime read while inactive not zero");
    input_read_level_a: assert property (
        s_in0_read |=> io_rdata_q == $past(pin_in[7:0]))
        else $error("input read does not match pin levels");
    cfg_read_hold_a: assert property (!cfg_rd |=> $stable(cfg_rdata_q))
        else $error("config read data moved without a read");
    io_read_hold_a: assert property (!io_rd |=> $stable(io_rdata_q))
        else $error("runtime read data moved without a read");
    unknown_index_zero_a: assert property (
        cfg_rd && !(cfg_index inside {8'hF0, 8'hF1, 8'hF2})
        |=> cfg_rdata_q == 0) else $error("unknown index read not zero");
    selector_reserved_a: assert property (
        cfg_rd && cfg_index == 8'hF0 |=> (cfg_rdata_q & 8'hC8) == 0)
        else $error("selector reserved bits set");
    unmapped_offset_zero_a: assert property (
        io_rd && (io_addr inside {2, 3, 6, 7} || io_addr > 9)
        |=> io_rdata_q == 0) else $error("unmapped offset read not zero");
    pullup_impl_only_a: assert property ((pin_pullup_q & ~IMPL) == 0)
        else $error("pull-up on an absent pin");
    latch_no_write_a: assert property (
        !(io_wr && port_active) |=> ##1 $stable(pin_out_q))
        else $error("pin output moved without a latch write");
endmodule
bind gpcp_top gpcp_assertions #(.IMPL(IMPL)) u_chk (.clk(clk), .rst(rst),
    .cfg_rd(cfg_rd), .cfg_index(cfg_index), .cfg_rdata_q(cfg_rdata_q),
    .port_active(port_active), .io_wr(io_wr), .io_rd(io_rd),
    .io_addr(io_addr), .io_rdata_q(io_rdata_q), .pin_in(pin_in),
    .pin_out_q(pin_out_q), .pin_pullup_q(pin_pullup_q));

// >>> dv/gpcp_pin_model.sv
// Purpose: external devices and wiring on the general-purpose pins
// Assumes: bench chooses which pins an outside device drives
// Notes: a floating pin toggles so a stale value never reads as valid
`timescale 1ns/1ps
module gpcp_pin_model (
    // clock
    input wire logic clk,
    // device side
    input wire logic [23:0] pin_out_q,
    input wire logic [23:0] pin_oe_q,
    input wire logic [23:0] pin_pullup_q,
    // outside device
    input wire logic [23:0] ext_en,
    input wire logic [23:0] ext_val,
    // resolved level
    output logic [23:0] pin_lvl
);
    logic [23:0] last_q = 24'h00_0000;
    logic [23:0] idle;
    assign idle = ~pin_oe_q & ~ext_en;
    assign pin_lvl = (pin_oe_q & pin_out_q) | (~pin_oe_q & ext_en & ext_val)
        | (idle & pin_pullup_q) | (idle & ~pin_pullup_q & ~last_q);
    always_ff @(posedge clk) begin
        last_q <= pin_lvl;
    end
endmodule

// >>> dv/gpio_pin_config_port_bench.sv
// Purpose: self-checking bench of the pin config port
// Assumes: inputs change 1 ns after the rising edge
// Notes: debounce shortened to 8 cycles to keep the run brief
`timescale 1ns/1ps
module gpio_pin_config_port_bench;
    logic clk = 0, rst = 1, cfg_wr = 0, cfg_rd = 0, port_active = 1;
    logic io_wr = 0, io_rd = 0;
    logic [7:0] cfg_index = 0, cfg_wdata = 0, io_wdata = 0;
    logic [3:0] io_addr = 0;
    logic [23:0] ext_en = ~24'h1F_801F, ext_val = 0, pin_in;
    logic [7:0] cfg_rdata_q, io_rdata_q;
    logic [23:0] pin_out_q, pin_oe_q, pin_pullup_q;
    logic [15:0] evt_active_q, evt_level_kind_q, evt_irq_route_q;
    int n_errors = 0, n_tests = 0, cycles = 0;
    gpcp_top #(.DBNC_CYCLES(8)) i_dut (.clk(clk), .rst(rst),
        .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_index(cfg_index),
        .cfg_wdata(cfg_wdata), .cfg_rdata_q(cfg_rdata_q),
        .port_active(port_active), .io_wr(io_wr), .io_rd(io_rd),
        .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata_q(io_rdata_q),
        .pin_in(pin_in), .pin_out_q(pin_out_q), .pin_oe_q(pin_oe_q),
        .pin_pullup_q(pin_pullup_q), .evt_active_q(evt_active_q),
        .evt_level_kind_q(evt_level_kind_q),
        .evt_irq_route_q(evt_irq_route_q));
    gpcp_pin_model u_pins (.clk(clk), .pin_out_q(pin_out_q),
        .pin_oe_q(pin_oe_q), .pin_pullup_q(pin_pullup_q), .ext_en(ext_en),
        .ext_val(ext_val), .pin_lvl(pin_in));
    initial begin
        forever #50 clk = ~clk;
    end
    task automatic end_sim;
        $display("tests %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // generous ceiling: the whole sequence needs about 130 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            end_sim();
        end
    end
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cw(input logic [7:0] idx, input logic [7:0] d);
        cfg_index = idx;
        cfg_wdata = d;
        cfg_wr = 1;
        @(posedge clk) #1;
        cfg_wr = 0;
        // idle cycle so a following write never re-raises in one step
        @(posedge clk) #1;
    endtask
    task automatic cr(input logic [7:0] idx, input logic [7:0] exp);
        cfg_index = idx;
        cfg_rd = 1;
        @(posedge clk) #1;
        cfg_rd = 0;
        chk(24'(cfg_rdata_q), 24'(exp));
        @(posedge clk) #1;
    endtask
    task automatic iw(input logic [3:0] a, input logic [7:0] d);
        io_addr = a;
        io_wdata = d;
        io_wr = 1;
        @(posedge clk) #1;
        io_wr = 0;
        @(posedge clk) #1;
    endtask
    task automatic ir(input logic [3:0] a, input logic [7:0] exp);
        io_addr = a;
        io_rd = 1;
        @(posedge clk) #1;
        io_rd = 0;
        chk(24'(io_rdata_q), 24'(exp));
        @(posedge clk) #1;
    endtask
    task automatic t_reset;
        cr(8'hF0, 8'h00);
        cr(8'hF1, 8'h44);
        cr(8'hF2, 8'h00);
        cw(8'hF0, 8'h20);
        cr(8'hF1, 8'h04);
        cw(8'hF0, 8'h17);
        cr(8'hF1, 8'h44);
        ir(4'h0, 8'hFF);
        ir(4'h4, 8'hFF);
        ir(4'h8, 8'hFF);
        chk(pin_pullup_q, 24'h1F_801F);
        chk(pin_oe_q, 24'h0);
        $display("test reset done");
    endtask
    task automatic t_lock;
        cw(8'hF0, 8'h02);
        cw(8'hF1, 8'h0C);
        cw(8'hF1, 8'h7B);
        cr(8'hF1, 8'h7C);
        iw(4'h0, 8'h00);
        ir(4'h0, 8'h04);
        $display("test lock done");
    endtask
    task automatic t_cfg;
        cw(8'hF0, 8'h01);
        cw(8'hF1, 8'h74);
        cr(8'hF1, 8'h74);
        chk(24'(evt_level_kind_q[1]), 24'h1);
        cw(8'hF2, 8'hFF);
        cr(8'hF2, 8'h01);
        chk(24'(evt_irq_route_q[1]), 24'h1);
        cw(8'hF0, 8'h21);
        cw(8'hF1, 8'hFF);
        cr(8'hF1, 8'h0F);
        cw(8'hF2, 8'h01);
        cr(8'hF2, 8'h00);
        cw(8'hF0, 8'hFF);
        cr(8'hF0, 8'h37);
        cr(8'hF1, 8'h00);
        cw(8'hF0, 8'h05);
        cw(8'hF1, 8'h74);
        cr(8'hF1, 8'h00);
        cr(8'hF3, 8'h00);
        $display("test config done");
    endtask
    task automatic t_drive;
        cw(8'hF0, 8'h00);
        cw(8'hF1, 8'h07);
        iw(4'h0, 8'h00);
        chk(24'({pin_oe_q[0], pin_out_q[0]}), 24'h2);
        ir(4'h1, 8'h1E);
        cw(8'hF1, 8'h05);
        iw(4'h0, 8'h01);
        chk(24'(pin_oe_q[0]), 24'h0);
        iw(4'h1, 8'h00);
        ir(4'h0, 8'h05);
        ir(4'h1, 8'h1F);
        $display("test drive done");
    endtask
    task automatic t_inactive;
        port_active = 0;
        iw(4'h0, 8'hFF);
        ir(4'h0, 8'h00);
        port_active = 1;
        ir(4'h0, 8'h05);
        chk(24'(pin_out_q[7:0]), 24'h5);
        foreach (ext_val[k]) begin
            if (k < 6) begin
                // offsets 2,3,6,7,10,11 carry no register here
                ir(4'(k < 2 ? k + 2 : (k < 4 ? k + 4 : k + 6)), 8'h00);
            end
        end
        $display("test inactive done");
    endtask
    task automatic t_debounce;
        ext_en[3] = 1;
        repeat (4) @(posedge clk);
        #1;
        chk(24'(evt_active_q[3]), 24'h0);
        repeat (8) @(posedge clk);
        #1;
        chk(24'(evt_active_q[3]), 24'h1);
        $display("test debounce done");
    endtask
    initial begin
        repeat (10) @(posedge clk);
        #1;
        rst = 0;
        @(posedge clk) #1;
        t_reset();
        t_lock();
        t_cfg();
        t_drive();
        t_inactive();
        t_debounce();
        end_sim();
    end
endmodule

// >>> logic/gpcp_debounce.sv
// Purpose: passes an input on only after it has been stable a full period
// Assumes: raw input synchronous to clk
// Notes: any bounce back restarts the wait
`timescale 1ns/1ps
`include "gpcp_defines.svh"
module gpcp_debounce #(
    parameter int CYCLES = 160000
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // signal
    input wire logic raw,
    output logic filt_q
);
    localparam int CW = $clog2(CYCLES + 1);
    logic [CW-1:0] cnt_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q <= '0;
            filt_q <= `GPCP_FILT_RST;
        end else if (raw == filt_q) begin
            cnt_q <= '0;
        end else if (cnt_q == CW'(CYCLES - 1)) begin
            cnt_q <= '0;
            filt_q <= raw; // RQ5
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end
endmodule

// >>> logic/gpcp_defines.svh
// Purpose: named offsets, field positions, reset values and timings
// Assumes: included by bare name from every design file that needs it
// Notes: definitions only
`ifndef GPCP_DEFINES_SVH
`define GPCP_DEFINES_SVH
// configuration space indexes
`define GPCP_IDX_SEL 8'hF0
`define GPCP_IDX_CFG 8'hF1
`define GPCP_IDX_RTE 8'hF2
// runtime offsets inside the 16-byte block
`define GPCP_OFS_OUT0 4'h0
`define GPCP_OFS_IN0 4'h1
`define GPCP_OFS_OUT1 4'h4
`define GPCP_OFS_IN1 4'h5
`define GPCP_OFS_OUT2 4'h8
`define GPCP_OFS_IN2 4'h9
// selector fields
`define GPCP_SEL_MASK 8'h37
`define GPCP_PORT_HI 5
`define GPCP_PORT_LO 4
`define GPCP_PIN_HI 2
`define GPCP_PIN_LO 0
// per-pin configuration
`define GPCP_CFG_RST_EV 8'h44
`define GPCP_CFG_RST_NE 8'h04
`define GPCP_CFG_MASK_EV 8'h7F
`define GPCP_CFG_MASK_NE 8'h0F
`define GPCP_CFG_LOCKED 8'h0F
`define GPCP_RTE_MASK 8'h01
`define GPCP_RTE_RST 1'b0
`define GPCP_LATCH_RST 8'hFF
`define GPCP_ZERO8 8'h00
`define GPCP_FILT_RST 1'b1
// implemented pins per port
`define GPCP_IMPL0 8'h1F
`define GPCP_IMPL1 8'h80
`define GPCP_IMPL2 8'h1F
// debounce time
`define GPCP_DBNC_MS 16
`define GPCP_CLK_HZ 10000000
`endif

// >>> logic/gpcp_pin_drive.sv
// Purpose: turns latch and drive settings into pin drive and enable
// Assumes: open-drain drives only the low level
// Notes: outputs registered, one cycle after the controls
`timescale 1ns/1ps
module gpcp_pin_drive #(
    parameter int NPIN = 24
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // controls
    gpcp_pin_if.drv ctl,
    // pins
    output logic [NPIN-1:0] pin_out_q,
    output logic [NPIN-1:0] pin_oe_q
);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_out_q <= '0;
            pin_oe_q <= '0;
        end else begin
            pin_out_q <= ctl.latch; // RQ15
            // push-pull drives both levels, open-drain only low
            pin_oe_q <= ctl.drive_on &
                (ctl.drive_kind | ~ctl.latch); // RQ10 RQ11
        end
    end
endmodule

// >>> logic/gpcp_pin_if.sv
// Purpose: carries per-pin drive controls from the register file
// Assumes: one bit per pin, pin n of port p at index p*8+n
// Notes: no clocking
`timescale 1ns/1ps
interface gpcp_pin_if #(parameter int NPIN = 24);
    logic [NPIN-1:0] drive_on;
    logic [NPIN-1:0] drive_kind;
    logic [NPIN-1:0] latch;
    modport ctrl (output drive_on, output drive_kind, output latch);
    modport drv (input drive_on, input drive_kind, input latch);
endinterface

// >>> logic/gpcp_pkg.sv
// Purpose: shared types of the pin configuration port
// Assumes: nothing
// Notes: used only as gpcp_pkg::name
package gpcp_pkg;
    typedef logic [7:0] gpcp_byte_t;
    typedef enum logic [1:0] {
        GPCP_PORT0 = 2'h0,
        GPCP_PORT1 = 2'h1,
        GPCP_PORT2 = 2'h2,
        GPCP_PORT_RSVD = 2'h3
    } gpcp_port_t;
    typedef struct packed {
        logic rsvd;
        logic event_debounce_on;
        logic event_polarity;
        logic event_trigger_kind;
        logic pin_config_lock;
        logic pullup_on;
        logic drive_kind;
        logic drive_on;
    } gpcp_cfg_t;
endpackage

// >>> logic/gpcp_top.sv
// Purpose: per-pin configuration window and basic runtime port registers
// Assumes: config and runtime strobes are one-cycle, synchronous to clk
// Notes: event detection and pending logic live outside this block
//
// Operation
// RQ1: selector bits 5-4 choose port 0-2
// RQ2: selector bits 2-0 choose pin number
// RQ3: window accesses the selected pin's register
// RQ4: config resets 44h ports 0-1, 04h port 2
// RQ5: bit 6 enables debounce; port 2 zero
// RQ6: bit 5 is event polarity; port 2 zero
// RQ7: bit 4 is edge or level; port 2 zero
// RQ8: bit 3 sticky lock guards config and latch
// RQ9: bit 2 enables weak pull-up
// RQ10: bit 1 selects open-drain or push-pull
// RQ11: bit 0 enables driver, input unaffected
// RQ12: routing bit 0 enables event to irq
// RQ13: two 8-bit registers per pin
// RQ14: runtime register bit n is pin n
// RQ15: latch drives enabled pin, reads back stored
// RQ16: input register reads pin levels, ignores writes
// RQ17: inactive port blocks runtime data access only
// RQ18: latch resets all ones, locked bits kept
// RQ19: runtime block decodes low four address bits
// RQ20: unimplemented pin ignores writes, reads zero; only the config space does so, runtime registers are unmasked
`timescale 1ns/1ps
`include "gpcp_defines.svh"
module gpcp_top #(
    parameter int NPORT = 3,
    parameter int NEV = 16,
    parameter int DBNC_MS = `GPCP_DBNC_MS,
    parameter int CLK_HZ = `GPCP_CLK_HZ,
    parameter int DBNC_CYCLES = DBNC_MS * (CLK_HZ / 1000),
    parameter logic [23:0] IMPL = {`GPCP_IMPL2, `GPCP_IMPL1, `GPCP_IMPL0}
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // configuration space access
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [7:0] cfg_index,
    input wire logic [7:0] cfg_wdata,
    output logic [7:0] cfg_rdata_q,
    // runtime access
    input wire logic port_active,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [3:0] io_addr,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata_q,
    // pins
    input wire logic [23:0] pin_in,
    output logic [23:0] pin_out_q,
    output logic [23:0] pin_oe_q,
    output logic [23:0] pin_pullup_q,
    // event sources for the external event logic
    output logic [15:0] evt_active_q,
    output logic [15:0] evt_level_kind_q,
    output logic [15:0] evt_irq_route_q
);
    localparam int NPIN = NPORT * 8;

    gpcp_pkg::gpcp_byte_t sel_q;
    gpcp_pkg::gpcp_cfg_t cfg_q [NPIN];
    logic [NEV-1:0] route_q;
    gpcp_pkg::gpcp_byte_t latch_q [NPORT];
    logic [NEV-1:0] filt;
    logic [NPIN-1:0] lock_vec;
    logic [4:0] sidx;
    logic simpl;
    logic sevt;

    gpcp_pin_if #(.NPIN(NPIN)) pin_ctl ();

    // flat pin index: port in the upper two bits, pin in the lower three
    function automatic logic [4:0] sel_index(input logic [7:0] s);
        sel_index = {s[`GPCP_PORT_HI:`GPCP_PORT_LO],
            s[`GPCP_PIN_HI:`GPCP_PIN_LO]}; // RQ1 RQ2
    endfunction

    // the reserved port code names no pin at all
    function automatic logic sel_impl(input logic [7:0] s);
        logic [4:0] i;
        i = sel_index(s);
        if (s[`GPCP_PORT_HI:`GPCP_PORT_LO] == gpcp_pkg::GPCP_PORT_RSVD) begin
            sel_impl = 1'b0; // RQ1
        end else begin
            sel_impl = IMPL[i]; // RQ20
        end
    endfunction

    function automatic logic sel_event(input logic [7:0] s);
        sel_event = (s[`GPCP_PORT_HI:`GPCP_PORT_LO] ==
            gpcp_pkg::GPCP_PORT0) || (s[`GPCP_PORT_HI:`GPCP_PORT_LO] ==
            gpcp_pkg::GPCP_PORT1);
    endfunction

    function automatic logic [7:0] cfg_mask(input logic evt);
        cfg_mask = evt ? `GPCP_CFG_MASK_EV : `GPCP_CFG_MASK_NE;
    endfunction

    assign sidx = sel_index(sel_q);
    assign simpl = sel_impl(sel_q);
    assign sevt = sel_event(sel_q);

    // pin selector
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sel_q <= `GPCP_ZERO8; // RQ1 RQ2
        end else if (cfg_wr && cfg_index == `GPCP_IDX_SEL) begin
            sel_q <= cfg_wdata & `GPCP_SEL_MASK;
        end
    end

    // per-pin configuration registers behind the window
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NPIN; i++) begin
                if (i < NEV) begin
                    cfg_q[i] <= `GPCP_CFG_RST_EV; // RQ4
                end else begin
                    cfg_q[i] <= `GPCP_CFG_RST_NE; // RQ4
                end
            end
        end else if (cfg_wr && cfg_index == `GPCP_IDX_CFG && simpl) begin
            cfg_q[sidx] <= cfg_next(cfg_q[sidx], cfg_wdata, sevt); // RQ3
        end
    end

    // write merge: lock is set-only and freezes the low bits with it;
    // event bits stay writable so a locked pin can still be retuned
    function automatic logic [7:0] cfg_next(
        input logic [7:0] old,
        input logic [7:0] wd,
        input logic evt
    );
        logic [7:0] n;
        n = wd;
        if (old[3]) begin
            n = (wd & ~`GPCP_CFG_LOCKED) | (old & `GPCP_CFG_LOCKED); // RQ8
        end else begin
            n[3] = wd[3]; // RQ8
        end
        cfg_next = n & cfg_mask(evt); // RQ5 RQ6 RQ7
    endfunction

    // event routing bit, ports 0 and 1 only
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            route_q <= '0; // RQ12
        end else if (cfg_wr && cfg_index == `GPCP_IDX_RTE && simpl &&
                sevt) begin
            route_q[sidx[3:0]] <= cfg_wdata[0]; // RQ12 RQ13
        end
    end

    // configuration space read path
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cfg_rdata_q <= `GPCP_ZERO8;
        end else if (cfg_rd) begin
            case (cfg_index)
                `GPCP_IDX_SEL: begin
                    cfg_rdata_q <= sel_q;
                end
                `GPCP_IDX_CFG: begin
                    if (simpl) begin
                        cfg_rdata_q <= cfg_q[sidx] & cfg_mask(sevt); // RQ3
                    end else begin
                        cfg_rdata_q <= `GPCP_ZERO8; // RQ20
                    end
                end
                `GPCP_IDX_RTE: begin
                    if (simpl && sevt) begin
                        cfg_rdata_q <= {7'h0, route_q[sidx[3:0]]}; // RQ12
                    end else begin
                        cfg_rdata_q <= `GPCP_ZERO8; // RQ20
                    end
                end
                default: begin
                    cfg_rdata_q <= `GPCP_ZERO8;
                end
            endcase
        end
    end

    // lock per pin, gathered for the latch write mask
    generate
        for (genvar g = 0; g < NPIN; g++) begin : g_lock
            assign lock_vec[g] = cfg_q[g].pin_config_lock;
            assign pin_ctl.drive_on[g] = cfg_q[g].drive_on; // RQ11
            assign pin_ctl.drive_kind[g] = cfg_q[g].drive_kind; // RQ10
        end
        for (genvar p = 0; p < NPORT; p++) begin : g_latch_map
            assign pin_ctl.latch[p*8 +: 8] = latch_q[p];
        end
    endgenerate

    // runtime output latches; offsets step by four per port
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int p = 0; p < NPORT; p++) begin
                latch_q[p] <= `GPCP_LATCH_RST; // RQ18
            end
        end else if (io_wr && port_active) begin // RQ17
            for (int p = 0; p < NPORT; p++) begin
                if (io_addr == out_ofs(p)) begin // RQ19
                    latch_q[p] <= (io_wdata & ~lock_vec[p*8 +: 8]) |
                        (latch_q[p] & lock_vec[p*8 +: 8]); // RQ8 RQ18
                end
            end
        end
    end

    function automatic logic [3:0] out_ofs(input int p);
        case (p)
            0: out_ofs = `GPCP_OFS_OUT0;
            1: out_ofs = `GPCP_OFS_OUT1;
            default: out_ofs = `GPCP_OFS_OUT2;
        endcase
    endfunction

    // runtime read path; the input register is read-only, so io_wr at
    // its offset falls through without effect
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            io_rdata_q <= `GPCP_ZERO8;
        end else if (io_rd) begin
            if (!port_active) begin
                io_rdata_q <= `GPCP_ZERO8; // RQ17
            end else begin
                case (io_addr) // RQ19
                    `GPCP_OFS_OUT0: io_rdata_q <= latch_q[0]; // RQ15
                    `GPCP_OFS_OUT1: io_rdata_q <= latch_q[1]; // RQ15
                    `GPCP_OFS_OUT2: io_rdata_q <= latch_q[2]; // RQ15
                    `GPCP_OFS_IN0: io_rdata_q <= pin_in[7:0]; // RQ16 RQ14
                    `GPCP_OFS_IN1: io_rdata_q <= pin_in[15:8]; // RQ16
                    `GPCP_OFS_IN2: io_rdata_q <= pin_in[23:16]; // RQ16
                    default: io_rdata_q <= `GPCP_ZERO8;
                endcase
            end
        end
    end

    // pull-up follows its bit whatever the pin direction
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_pullup_q <= '0;
        end else begin
            for (int i = 0; i < NPIN; i++) begin
                pin_pullup_q[i] <= cfg_q[i].pullup_on & IMPL[i]; // RQ9
            end
        end
    end

    gpcp_pin_drive #(.NPIN(NPIN)) u_drive (
        .clk(clk),
        .rst(rst),
        .ctl(pin_ctl.drv),
        .pin_out_q(pin_out_q),
        .pin_oe_q(pin_oe_q)
    );

    // one filter per event-capable pin; port 2 has no event path
    generate
        for (genvar e = 0; e < NEV; e++) begin : g_dbnc
            gpcp_debounce #(.CYCLES(DBNC_CYCLES)) u_dbnc (
                .clk(clk),
                .rst(rst),
                .raw(pin_in[e]),
                .filt_q(filt[e])
            );
        end
    endgenerate

    // event source level: high when the pin sits at its active level;
    // the debounce delays both edges, so level events see it on release
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            evt_active_q <= '0;
            evt_level_kind_q <= '0;
            evt_irq_route_q <= '0;
        end else begin
            for (int e = 0; e < NEV; e++) begin
                evt_active_q[e] <= IMPL[e] &
                    ((cfg_q[e].event_debounce_on ? filt[e] : pin_in[e]) ==
                    cfg_q[e].event_polarity); // RQ5 RQ6
                evt_level_kind_q[e] <= IMPL[e] &
                    cfg_q[e].event_trigger_kind; // RQ7
                evt_irq_route_q[e] <= IMPL[e] & route_q[e]; // RQ12
            end
        end
    end
endmodule
